/* File: config_regfile.v */
`timescale 1ns/1ps
`include "watchdog_map.vh"
// ==========================================================
// small register store for watchdog configuration bytes
module config_regfile
(
    input  wire       clock,
    input  wire       resetN,
    input  wire       writeEn,
    input  wire [1:0] writeSel,
    input  wire [7:0] writeData,
    input  wire [1:0] readSel,
    output reg  [7:0] readData,
    output reg  [7:0] ldevSelect,
    output reg  [7:0] devActivate,
    output reg  [7:0] timeUnit,
    output reg  [7:0] timeoutCount
);
    always @(posedge clock or negedge resetN)
    begin
        if (!resetN)
        begin
            ldevSelect   <= `RST_LDEV_SELECT;
            devActivate  <= `RST_DEV_ACTIVATE;
            timeUnit     <= `RST_TIME_UNIT;
            timeoutCount <= `RST_TIMEOUT_COUNT;
            readData     <= 8'h00;
        end
        else
        begin
            if (writeEn)
            begin
                case (writeSel)
                    2'd0: ldevSelect   <= writeData;
                    2'd1: devActivate  <= writeData;
                    2'd2: timeUnit     <= writeData;
                    default: timeoutCount <= writeData;
                endcase
            end
            case (readSel)
                2'd0: readData <= ldevSelect;
                2'd1: readData <= devActivate;
                2'd2: readData <= timeUnit;
                default: readData <= timeoutCount;
            endcase
        end
    end
endmodule // config_regfile

/* File: superio_watchdog_properties.sv */
`timescale 1ns/1ps
// ==========================================
// port checker for the watchdog
module superio_watchdog_checker
#(
    parameter RESET_PULSE_CYC = 250
)
(
    input wire       clock,
    input wire       rstn,
    input wire       ioWrite,
    input wire       ioRead,
    input wire       dataPortSel,
    input wire [7:0] ioWriteData,
    input wire [7:0] ioReadData,
    input wire       configOpen,
    input wire       watchdogRunning,
    input wire       systemResetPulse
);
    // counter, since the pulse is too long for a repetition
    reg [31:0] pulseCnt_reg;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    always @(posedge clock or negedge rstn)
        if (!rstn)
            pulseCnt_reg <= 32'h0;
        else
            pulseCnt_reg <= systemResetPulse ? pulseCnt_reg + 32'h1 : 32'h0;
    // expiry clears the run flag one cycle before the pulse shows
    chk_pulse_source: assert property ($rose(systemResetPulse) |->
        $past(watchdogRunning, 2)) else $error("pulse while disarmed");
    chk_pulse_width: assert property ($fell(systemResetPulse) |->
        pulseCnt_reg == RESET_PULSE_CYC) else $error("pulse width");
    // the open flag lags the lock state by one cycle
    chk_locked_read: assert property (ioRead ##1 !configOpen |->
        ioReadData == 8'hFF) else $error("locked read not FF");
    chk_unlock_pair: assert property ($rose(configOpen) |->
        $past(ioWrite, 2) && !$past(dataPortSel, 2) &&
        $past(ioWriteData, 2) == 8'h87)
        else $error("opened without unlock byte");
    chk_open_stable: assert property (!(ioWrite && !dataPortSel) |->
        ##2 $stable(configOpen)) else $error("open flag moved");
    chk_armed_quiet: assert property ($rose(watchdogRunning) &&
        !systemResetPulse |-> !systemResetPulse [*3])
        else $error("pulse too soon");
    chk_stop_quiet: assert property (!watchdogRunning &&
        !$past(watchdogRunning) && !systemResetPulse |=>
        !systemResetPulse) else $error("pulse stopped");
    chk_arm_by_write: assert property ($rose(watchdogRunning) |->
        $past(configOpen) && $past(ioWrite) && $past(dataPortSel))
        else $error("armed without data write");
endmodule // superio_watchdog_checker
bind superio_watchdog_reset_timer superio_watchdog_checker
    #(.RESET_PULSE_CYC(RESET_PULSE_CYC)) i_chk (.clock(clock), .rstn(rstn),
    .ioWrite(ioWrite), .ioRead(ioRead), .dataPortSel(dataPortSel),
    .ioWriteData(ioWriteData), .ioReadData(ioReadData),
    .configOpen(configOpen), .watchdogRunning(watchdogRunning),
    .systemResetPulse(systemResetPulse));

/* File: superio_watchdog_reset_timer.v */
// How it works
// - countdown expiring unreloaded pulses the system reset output.
// - two unlock bytes to index port open configuration; else ignored.
// - time unit register: 08 counts minutes, 00 counts seconds.
// - count register holds 8-bit timeout 0..255; 1..255 usable.
// - each write of the count register reloads the countdown.
// - writing 00 to activation stops the watchdog, except in the cycle of the last count step.
`timescale 1ns/1ps
`include "watchdog_map.vh"
module superio_watchdog_reset_timer
#(
    parameter TICKS_PER_SECOND = `CLOCK_HZ,
    parameter SECONDS_PER_MIN  = `SECONDS_PER_MIN,
    parameter RESET_PULSE_CYC  = `RESET_PULSE_CYC
)
(
    input  wire       clock,
    input  wire       rstn,
    input  wire       ioWrite,
    input  wire       ioRead,
    input  wire       dataPortSel,
    input  wire [7:0] ioWriteData,
    output reg  [7:0] ioReadData,
    output reg        configOpen,
    output reg        watchdogRunning,
    output reg        systemResetPulse
);
    // ======================================================
    // reset release
    // release is synchronised so no flop on resetN sees reset drop near an edge
    reg syncStage1_reg;
    reg syncStage2_reg;
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            syncStage1_reg <= 1'b0;
            syncStage2_reg <= 1'b0;
        end
        else
        begin
            syncStage1_reg <= 1'b1;
            syncStage2_reg <= syncStage1_reg;
        end
    end
    wire resetN = syncStage2_reg;

    // ======================================================
    // index/data port decoding
    localparam ST_LOCKED = 3'b001;
    localparam ST_HALF   = 3'b010;
    localparam ST_OPEN   = 3'b100;
    reg [2:0] unlock_reg;
    reg [7:0] index_reg;
    wire [7:0] ldevSelect;
    wire [7:0] devActivate;
    wire [7:0] timeUnit;
    wire [7:0] timeoutCount;
    wire [7:0] regReadData;

    function [2:0] decodeIndex;
        input [7:0] idx;
        begin
            if (idx == `IDX_LDEV_SELECT)
                decodeIndex = 3'b100;
            else if (idx == `IDX_DEV_ACTIVATE)
                decodeIndex = 3'b101;
            else if (idx == `IDX_TIME_UNIT)
                decodeIndex = 3'b110;
            else if (idx == `IDX_TIMEOUT_COUNT)
                decodeIndex = 3'b111;
            else
                decodeIndex = 3'b000;
        end
    endfunction

    wire [2:0] idxHit = decodeIndex(index_reg);
    wire isOpen = (unlock_reg == ST_OPEN);
    // device-wide select lives at 07; others only when device 08 chosen
    wire devSel = (ldevSelect == `WATCHDOG_LDEV_NUMBER);
    wire idxOk = idxHit[2] &&
                 ((idxHit[1:0] == 2'd0) || devSel);
    wire dataWrite = ioWrite && dataPortSel && isOpen && idxOk;
    wire countWrite = dataWrite && (idxHit[1:0] == 2'd3);

    always @(posedge clock or negedge resetN)
    begin
        if (!resetN)
        begin
            unlock_reg <= ST_LOCKED;
            index_reg  <= 8'h00;
        end
        else if (ioWrite && !dataPortSel)
        begin
            case (unlock_reg)
                ST_LOCKED:
                    unlock_reg <= (ioWriteData == `UNLOCK_BYTE) ?
                                  ST_HALF : ST_LOCKED;
                ST_HALF:
                    unlock_reg <= (ioWriteData == `UNLOCK_BYTE) ?
                                  ST_OPEN : ST_LOCKED;
                ST_OPEN:
                begin
                    if (ioWriteData == `LOCK_BYTE)
                        unlock_reg <= ST_LOCKED;
                    else
                        index_reg <= ioWriteData;
                end
                default: unlock_reg <= ST_LOCKED;
            endcase
        end
    end

    config_regfile regs
    (
        .clock        (clock),
        .resetN       (resetN),
        .writeEn      (dataWrite),
        .writeSel     (idxHit[1:0]),
        .writeData    (ioWriteData),
        .readSel      (idxHit[1:0]),
        .readData     (regReadData),
        .ldevSelect   (ldevSelect),
        .devActivate  (devActivate),
        .timeUnit     (timeUnit),
        .timeoutCount (timeoutCount)
    );

    // ======================================================
    // host read port
    // refused reads return FF, as an idle bus would
    wire readHit = ioRead && dataPortSel && isOpen && idxOk;

    always @(posedge clock or negedge resetN)
    begin
        if (!resetN)
        begin
            ioReadData <= 8'h00;
            configOpen <= 1'b0;
        end
        else
        begin
            configOpen <= isOpen;
            ioReadData <= readHit ? regReadData : 8'hFF;
        end
    end

    // ======================================================
    // countdown
    reg [31:0] tick_reg;
    reg [5:0]  minute_reg;
    reg [7:0]  count_reg;
    reg [15:0] pulse_reg;
    wire active = devActivate[`ACTIVATE_BIT];
    wire useMinutes = timeUnit[`UNIT_MINUTE_BIT];
    wire secTick = (tick_reg == TICKS_PER_SECOND - 1);
    wire unitTick = secTick &&
                    (!useMinutes || minute_reg == SECONDS_PER_MIN - 1);
    // a reload in the same cycle beats the last count step; a stop write there does not, as activation is registered
    wire expireNow = active && !countWrite && watchdogRunning &&
                     unitTick && (count_reg == 8'h01);

    always @(posedge clock or negedge resetN)
    begin
        if (!resetN)
        begin
            tick_reg         <= 32'h0000_0000;
            minute_reg       <= 6'h00;
            count_reg        <= 8'h00;
            watchdogRunning  <= 1'b0;
        end
        else
        begin
            if (!active)
            begin
                // stop wins over any pending expiry
                watchdogRunning <= 1'b0;
                tick_reg        <= 32'h0000_0000;
                minute_reg      <= 6'h00;
                if (countWrite)
                    count_reg <= ioWriteData;
            end
            else if (countWrite)
            begin
                count_reg       <= ioWriteData;
                tick_reg        <= 32'h0000_0000;
                minute_reg      <= 6'h00;
                // zero means disarmed; 1..255 arm the timer
                watchdogRunning <= (ioWriteData != 8'h00);
            end
            else if (watchdogRunning)
            begin
                tick_reg <= secTick ? 32'h0000_0000 :
                            tick_reg + 32'h0000_0001;
                if (secTick)
                    minute_reg <= (minute_reg == SECONDS_PER_MIN - 1) ?
                                  6'h00 : minute_reg + 6'h01;
                if (unitTick)
                    count_reg <= count_reg - 8'h01;
                if (expireNow)
                    watchdogRunning <= 1'b0;
            end
        end
    end

    // ======================================================
    // reset pulse stretcher
    // fixed length so the system sees a clean reset level; a new
    // expiry needs a rearm first, so the pulse is never retriggered
    always @(posedge clock or negedge resetN)
    begin
        if (!resetN)
        begin
            pulse_reg        <= 16'h0000;
            systemResetPulse <= 1'b0;
        end
        else
        begin
            systemResetPulse <= (pulse_reg != 16'h0000);
            if (expireNow)
                pulse_reg <= RESET_PULSE_CYC[15:0];
            else if (pulse_reg != 16'h0000)
                pulse_reg <= pulse_reg - 16'h0001;
        end
    end
endmodule // superio_watchdog_reset_timer

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    // short time base so a whole countdown fits in a few cycles
    localparam TPS = 4;
    localparam SPM = 3;
    reg        clock = 1'b0;
    reg        rstn = 1'b0;
    reg        ioWrite = 1'b0;
    reg        ioRead = 1'b0;
    reg        dataPortSel = 1'b0;
    reg  [7:0] ioWriteData = 8'h00;
    wire [7:0] ioReadData;
    wire       configOpen;
    wire       watchdogRunning;
    wire       systemResetPulse;
    reg  [7:0] rv;
    reg        hung = 1'b0;
    integer    error_cnt = 0;
    integer    samples_checked = 0;
    always #2 clock = ~clock;
    superio_watchdog_reset_timer #(.TICKS_PER_SECOND(TPS),
        .SECONDS_PER_MIN(SPM), .RESET_PULSE_CYC(4)) i_dut (.clock(clock),
        .rstn(rstn), .ioWrite(ioWrite), .ioRead(ioRead),
        .dataPortSel(dataPortSel), .ioWriteData(ioWriteData),
        .ioReadData(ioReadData), .configOpen(configOpen),
        .watchdogRunning(watchdogRunning),
        .systemResetPulse(systemResetPulse));
    // ==========================================
    // helpers
    task chk(input string nm, input [7:0] seen, input [7:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input p, input [7:0] d);
        @(posedge clock);
        ioWrite <= 1'b1;
        dataPortSel <= p;
        ioWriteData <= d;
        @(posedge clock);
        ioWrite <= 1'b0;
    endtask
    task cfg(input [7:0] idx, input [7:0] d);
        wr(1'b0, idx);
        wr(1'b1, d);
    endtask
    task rd(input [7:0] idx);
        wr(1'b0, idx);
        @(posedge clock);
        ioRead <= 1'b1;
        dataPortSel <= 1'b1;
        @(posedge clock);
        ioRead <= 1'b0;
        #1 rv = ioReadData;
    endtask
    // outputs are registered: look one edge after the last write
    task settle;
        @(posedge clock);
        #1;
    endtask
    task arm(input [7:0] unit, input [7:0] cnt);
        cfg(8'h07, 8'h08);
        cfg(8'h30, 8'h01);
        cfg(8'hF5, unit);
        cfg(8'hF6, cnt);
    endtask
    // bounded wait for the reset pulse; a miss skips later scenarios
    task expire(input integer lo, input integer hi, input fire);
        integer n;
        n = 0;
        while (n < hi && systemResetPulse !== 1'b1)
        begin
            @(posedge clock);
            #1 n = n + 1;
        end
        chk("reset pulse", systemResetPulse, fire);
        chk("expiry time", n >= lo, 1'b1);
        if (fire && systemResetPulse !== 1'b1)
            hung = 1'b1;
        cfg(8'h30, 8'h00);
        repeat (6) @(posedge clock);
    endtask
    // ==========================================
    // scenarios
    task s_locked;
        rd(8'h07);
        chk("locked read", rv, 8'hFF);
        wr(1'b0, 8'h87);
        wr(1'b0, 8'h07);
        wr(1'b0, 8'h87);
        settle;
        chk("split unlock", configOpen, 1'b0);
        wr(1'b0, 8'h87);
        settle;
        chk("unlocked", configOpen, 1'b1);
    endtask
    task s_ldev;
        cfg(8'h07, 8'h07);
        cfg(8'h30, 8'h01);
        cfg(8'hF6, 8'h01);
        settle;
        chk("wrong device", watchdogRunning, 1'b0);
        rd(8'hF6);
        chk("wrong device read", rv, 8'hFF);
    endtask
    task s_units;
        arm(8'h00, 8'h03);
        expire(3 * TPS - 2, 3 * TPS + 4, 1'b1);
        rd(8'hF6);
        chk("count readback", rv, 8'h03);
        arm(8'h08, 8'h02);
        expire(2 * TPS * SPM - 2, 2 * TPS * SPM + 4, 1'b1);
        rd(8'hF5);
        chk("unit readback", rv, 8'h08);
    endtask
    task s_reload;
        arm(8'h00, 8'h03);
        repeat (8) @(posedge clock);
        cfg(8'hF6, 8'h03);
        expire(3 * TPS - 2, 3 * TPS + 4, 1'b1);
    endtask
    task s_stop;
        arm(8'h00, 8'h03);
        repeat (4) @(posedge clock);
        cfg(8'h30, 8'h00);
        settle;
        chk("stopped", watchdogRunning, 1'b0);
        expire(20, 20, 1'b0);
        cfg(8'hF6, 8'hFF);
        settle;
        chk("inactive no arm", watchdogRunning, 1'b0);
        rd(8'hF6);
        chk("count max", rv, 8'hFF);
        cfg(8'h30, 8'h01);
        cfg(8'hF6, 8'hFF);
        settle;
        chk("armed max", watchdogRunning, 1'b1);
        cfg(8'hF6, 8'h00);
        settle;
        chk("zero disarms", watchdogRunning, 1'b0);
    endtask
    // index F6 is still selected, so a leaky lock would show here
    task s_relock;
        wr(1'b0, 8'hAA);
        settle;
        chk("relocked", configOpen, 1'b0);
        rd(8'h07);
        chk("relocked read", rv, 8'hFF);
        cfg(8'hF6, 8'h05);
        settle;
        chk("locked write", watchdogRunning, 1'b0);
    endtask
    task s_reset;
        wr(1'b0, 8'h87);
        wr(1'b0, 8'h87);
        arm(8'h00, 8'h05);
        settle;
        chk("armed", watchdogRunning, 1'b1);
        @(posedge clock);
        rstn <= 1'b0;
        settle;
        chk("reset stops", watchdogRunning, 1'b0);
        chk("reset locks", configOpen, 1'b0);
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        expire(30, 30, 1'b0);
        chk("still locked", configOpen, 1'b0);
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        s_locked;
        s_ldev;
        s_units;
        if (!hung)
            s_reload;
        if (!hung)
            s_stop;
        if (!hung)
            s_relock;
        if (!hung)
            s_reset;
        print_verdict;
    end
endmodule // tb

/* File: watchdog_map.vh */
`ifndef WATCHDOG_MAP_VH
`define WATCHDOG_MAP_VH
// ==========================================================
// configuration index offsets
`define IDX_LDEV_SELECT   8'h07
`define IDX_DEV_ACTIVATE  8'h30
`define IDX_TIME_UNIT     8'hF5
`define IDX_TIMEOUT_COUNT 8'hF6
// ==========================================================
// key values
`define UNLOCK_BYTE       8'h87
`define LOCK_BYTE         8'hAA
`define WATCHDOG_LDEV_NUMBER 8'h08
`define UNIT_MINUTES      8'h08
`define UNIT_SECONDS      8'h00
`define ACTIVATE_BIT      0
`define UNIT_MINUTE_BIT   3
// ==========================================================
// reset values
`define RST_LDEV_SELECT   8'h00
`define RST_DEV_ACTIVATE  8'h00
`define RST_TIME_UNIT     8'h00
`define RST_TIMEOUT_COUNT 8'h00
// ==========================================================
// timing
`define CLOCK_HZ          250000000
`define SECONDS_PER_MIN   60
`define RESET_PULSE_NS    1000
`define RESET_PULSE_CYC   ((`RESET_PULSE_NS * 250) / 1000)
`endif
